// [shared/msd_pkg.sv]
// Package with decode vector layout, register offsets and timing constants.
package msd_pkg;
    // Layout of the decode input vector seen by every product term.
    localparam int ADDR_LSB = 0;
    localparam int FETCH_BIT = 16;
    localparam int READ_BIT = 17;
    localparam int WRITE_BIT = 18;
    localparam int ALE_BIT = 19;
    localparam int RESET_BIT = 20;
    localparam int PDN_BIT = 21;
    localparam int PORT_LSB = 22;
    localparam int PORT_W = 22;
    localparam int PAGE_LSB = 44;
    localparam int FBA_LSB = 52;
    localparam int FBB_LSB = 60;
    localparam int READY_BIT = 68;
    localparam int VEC_W = 69;
    // Product term allocation inside the decode array.
    localparam int N_PRI = 8;
    localparam int N_SEC = 4;
    localparam int PT_PER_SECTOR = 3;
    localparam int PT_SRAM = 2;
    localparam int PT_PRI_BASE = 0;
    localparam int PT_SEC_BASE = 24;
    localparam int PT_SRAM_BASE = 36;
    localparam int PT_REG = 38;
    localparam int PT_PERI_BASE = 39;
    localparam int N_PT = 41;
    // Register block offsets, compared against the low address byte, and the register reset values.
    localparam logic [7:0] OFF_PAGE = 8'he0;
    localparam logic [7:0] OFF_SPACE_MAP = 8'he2;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] SPACE_MAP_BOOT = 8'h0c;
    // Space map field positions.
    localparam int VM_PERIPHERAL_IO_ENABLE = 7;
    localparam int VM_READ_PRI = 4;
    localparam int VM_READ_SEC = 3;
    localparam int VM_FETCH_PRI = 2;
    localparam int VM_FETCH_SEC = 1;
    localparam int VM_FETCH_SRAM = 0;
    // Standby delay of the logic arrays.
    localparam int CLK_PERIOD_PS = 50000;
    localparam int STANDBY_TIME_PS = 70000;
    localparam int STANDBY_CYCLES = (STANDBY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] STANDBY_CNT = 4'(STANDBY_CYCLES);

    // Default care masks: one sample map, to be replaced by the real programming.
    function automatic logic [N_PT-1:0][VEC_W-1:0] default_care();
        logic [N_PT-1:0][VEC_W-1:0] c;
        c = '0;
        c[PT_PRI_BASE][15:14] = 2'h3;
        c[PT_SEC_BASE][15:13] = 3'h7;
        c[PT_SRAM_BASE][15:11] = 5'h1f;
        c[PT_REG][15:8] = 8'hff;
        c[PT_PERI_BASE][15:8] = 8'hff;
        return c;
    endfunction : default_care

    // Default match values that pair with the care masks above.
    function automatic logic [N_PT-1:0][VEC_W-1:0] default_match();
        logic [N_PT-1:0][VEC_W-1:0] m;
        m = '0;
        m[PT_PRI_BASE][15:14] = 2'h2;
        m[PT_SEC_BASE][15:13] = 3'h4;
        m[PT_SRAM_BASE][15:11] = 5'h10;
        m[PT_REG][15:8] = 8'hff;
        m[PT_PERI_BASE][15:8] = 8'hf0;
        return m;
    endfunction : default_match

    localparam logic [N_PT-1:0] DEFAULT_USED = 41'h0_d001_000001;
endpackage : msd_pkg

// [hdl/msd_term.sv]
// One programmable product term of the decode array.
`timescale 1ns/1ps
module msd_term #(
    parameter int W = 69
) (
    input wire logic [W-1:0] vec_i,
    input wire logic [W-1:0] care_i,
    input wire logic [W-1:0] match_i,
    input wire logic used_i,
    output logic hit_o
);
    // A term fires when every cared bit equals its match bit.
    // An unused term never fires, so it can never widen a select.
    always_comb
    begin
        hit_o = used_i && (((vec_i ^ match_i) & care_i) == '0);
    end
endmodule : msd_term

// [hdl/msd_decoder.sv]
// Memory select decoder with page and space map registers.
`timescale 1ns/1ps
module msd_decoder #(
    parameter logic [msd_pkg::N_PT-1:0][msd_pkg::VEC_W-1:0] TERM_CARE = msd_pkg::default_care(),
    parameter logic [msd_pkg::N_PT-1:0][msd_pkg::VEC_W-1:0] TERM_MATCH =
        msd_pkg::default_match(),
    parameter logic [msd_pkg::N_PT-1:0] TERM_USED = msd_pkg::DEFAULT_USED,
    parameter logic [7:0] SPACE_MAP_INIT = msd_pkg::SPACE_MAP_BOOT
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [15:0] addr_i,
    input wire logic program_fetch_strobe_i,
    input wire logic read_strobe_i,
    input wire logic write_strobe_i,
    input wire logic addr_latch_i,
    input wire logic power_down_input_i,
    input wire logic [21:0] port_in_i,
    input wire logic [7:0] group_a_feedback_i,
    input wire logic [7:0] group_b_feedback_i,
    input wire logic flash_ready_i,
    input wire logic [7:0] data_i,
    input wire logic fast_mode_i,
    input wire logic battery_status_enable_i,
    input wire logic supply_below_battery_i,
    output logic [7:0] primary_sector_selects_o,
    output logic [3:0] secondary_sector_selects_o,
    output logic sram_select_o,
    output logic register_block_select_o,
    output logic [1:0] peripheral_selects_o,
    output logic [7:0] page_bits_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic battery_on_flag_o,
    output logic standby_o
);
    // Refuse a vector layout that the port widths cannot fill.
    if (msd_pkg::PORT_W != 22 || msd_pkg::VEC_W != msd_pkg::READY_BIT + 1)
    begin : g_bad_layout
        $error("decode vector layout does not match the ports");
    end

    // Reset synchroniser: asynchronous assert, two-flop release.
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Register state and its next values.
    logic [7:0] page_select;
    logic [7:0] space_map;
    logic [7:0] next_page_select;
    logic [7:0] next_space_map;

    // Decode input vector; the page bits come from the register itself.
    logic [msd_pkg::VEC_W-1:0] vec;
    always_comb
    begin
        vec = {flash_ready_i, group_b_feedback_i, group_a_feedback_i, page_select, port_in_i,
               power_down_input_i, !rst_n, addr_latch_i, write_strobe_i, read_strobe_i,
               program_fetch_strobe_i, addr_i};
    end

    // One product term per array entry; a single generate covers them all.
    logic [msd_pkg::N_PT-1:0] term_hit;
    for (genvar t = 0; t < msd_pkg::N_PT; t++)
    begin : g_term
        msd_term #(
            .W(msd_pkg::VEC_W)
        ) u_term (
            .vec_i(vec),
            .care_i(TERM_CARE[t]),
            .match_i(TERM_MATCH[t]),
            .used_i(TERM_USED[t]),
            .hit_o(term_hit[t])
        );
    end

    // Raw sector selects: each sector ORs its own three terms.
    logic [7:0] pri_raw;
    logic [3:0] sec_raw;
    for (genvar p = 0; p < msd_pkg::N_PRI; p++)
    begin : g_pri
        assign pri_raw[p] =
            |term_hit[msd_pkg::PT_PRI_BASE + 3*p +: msd_pkg::PT_PER_SECTOR];
    end
    for (genvar s = 0; s < msd_pkg::N_SEC; s++)
    begin : g_sec
        assign sec_raw[s] =
            |term_hit[msd_pkg::PT_SEC_BASE + 3*s +: msd_pkg::PT_PER_SECTOR];
    end

    // Level-one raw selects.
    logic sram_raw;
    logic reg_raw;
    logic [1:0] peri_raw;
    always_comb
    begin
        sram_raw = |term_hit[msd_pkg::PT_SRAM_BASE +: msd_pkg::PT_SRAM];
        reg_raw = term_hit[msd_pkg::PT_REG];
        peri_raw = term_hit[msd_pkg::PT_PERI_BASE +: 2];
    end

    // Space map gating: an active strobe whose bit is clear blocks that memory.
    // Flash and SRAM writes are never gated, so flash command writes still reach the sectors.
    logic pri_ok;
    logic sec_ok;
    logic sram_ok;
    logic peri_ok;
    always_comb
    begin
        // With 0ch fetches see only primary, reads see secondary and SRAM.
        pri_ok = !(program_fetch_strobe_i && !space_map[msd_pkg::VM_FETCH_PRI])
              && !(read_strobe_i && !space_map[msd_pkg::VM_READ_PRI]);
        sec_ok = !(program_fetch_strobe_i && !space_map[msd_pkg::VM_FETCH_SEC])
              && !(read_strobe_i && !space_map[msd_pkg::VM_READ_SEC]);
        sram_ok = !(program_fetch_strobe_i && !space_map[msd_pkg::VM_FETCH_SRAM]);
        peri_ok = space_map[msd_pkg::VM_PERIPHERAL_IO_ENABLE];
    end

    // Priority resolution over three levels, computed in the current cycle.
    logic [7:0] next_pri;
    logic [3:0] next_sec;
    logic next_sram;
    logic next_reg;
    logic [1:0] next_peri;
    logic lvl1_any;
    logic lvl2_any;
    always_comb
    begin
        next_sram = sram_raw && sram_ok;
        next_reg = reg_raw;
        next_peri = peri_ok ? peri_raw : 2'h0;
        lvl1_any = next_sram || next_reg || (next_peri != 2'h0);
        // Level one overrides all flash; this is why it is evaluated first.
        next_sec = (lvl1_any || !sec_ok) ? 4'h0 : sec_raw;
        lvl2_any = (next_sec != 4'h0);
        // Secondary sectors beat primary sectors at shared addresses.
        next_pri = (lvl1_any || lvl2_any || !pri_ok) ? 8'h00 : pri_raw;
        // Level-one windows must not overlap; if they do anyway, SRAM, then the register block, then peripheral 0 keeps the cycle
        // so that the one-hot property still holds.
        if (next_sram)
        begin
            next_reg = 1'b0;
            next_peri = 2'h0;
        end
        else if (next_reg)
        begin
            next_peri = 2'h0;
        end
        else if (next_peri == 2'h3)
        begin
            next_peri = 2'h1;
        end
    end

    // Register block access decode; uses the same-cycle register select.
    logic page_hit;
    logic vm_hit;
    logic next_oe;
    logic [7:0] next_data;
    always_comb
    begin
        page_hit = next_reg && (addr_i[7:0] == msd_pkg::OFF_PAGE);
        vm_hit = next_reg && (addr_i[7:0] == msd_pkg::OFF_SPACE_MAP);
        next_page_select = page_select;
        next_space_map = space_map;
        if (write_strobe_i && page_hit)
        begin
            next_page_select = data_i;
        end
        if (write_strobe_i && vm_hit)
        begin
            next_space_map = data_i;
        end
        // Only a read of a mapped register drives the bus; nothing else does.
        next_oe = read_strobe_i && (page_hit || vm_hit);
        if (page_hit)
        begin
            next_data = page_select;
        end
        else if (vm_hit)
        begin
            next_data = space_map;
        end
        else
        begin
            next_data = 8'h00;
        end
    end

    // Registers: the space map restarts from its boot value on every reset.
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            page_select <= msd_pkg::PAGE_RESET;
            space_map <= 8'h00;
        end
        else if (!rst_n)
        begin
            page_select <= msd_pkg::PAGE_RESET;
            space_map <= SPACE_MAP_INIT;
        end
        else
        begin
            page_select <= next_page_select;
            space_map <= next_space_map;
        end
    end

    // Standby timer: counts cycles with an unchanged decode vector.
    logic [msd_pkg::VEC_W-1:0] vec_q;
    logic [3:0] idle_cnt;
    logic [3:0] next_idle_cnt;
    logic next_standby;
    always_comb
    begin
        if (fast_mode_i || (vec != vec_q))
        begin
            next_idle_cnt = 4'h0;
        end
        else if (idle_cnt != msd_pkg::STANDBY_CNT)
        begin
            next_idle_cnt = idle_cnt + 4'h1;
        end
        else
        begin
            next_idle_cnt = idle_cnt;
        end
        // Standby only trades speed for power; any change wakes the arrays.
        next_standby = (next_idle_cnt == msd_pkg::STANDBY_CNT);
    end

    // Output and tracking flops; every output leaves a flop.
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            primary_sector_selects_o <= 8'h00;
            secondary_sector_selects_o <= 4'h0;
            sram_select_o <= 1'b0;
            register_block_select_o <= 1'b0;
            peripheral_selects_o <= 2'h0;
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
            battery_on_flag_o <= 1'b0;
            standby_o <= 1'b0;
            vec_q <= '0;
            idle_cnt <= 4'h0;
        end
        else
        begin
            primary_sector_selects_o <= next_pri;
            secondary_sector_selects_o <= next_sec;
            sram_select_o <= next_sram;
            register_block_select_o <= next_reg;
            peripheral_selects_o <= next_peri;
            data_o <= next_data;
            data_oe_o <= next_oe;
            battery_on_flag_o <= battery_status_enable_i && supply_below_battery_i;
            standby_o <= next_standby;
            vec_q <= vec;
            idle_cnt <= next_idle_cnt;
        end
    end

    // The page bits are visible to general logic straight from the register.
    assign page_bits_o = page_select;

    // Checks on the resolved selects and registers.
    property p_one_hot;
        @(posedge clock_i) disable iff (!rst_n)
        $onehot0({primary_sector_selects_o, secondary_sector_selects_o, sram_select_o,
                  register_block_select_o, peripheral_selects_o});
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("more than one select");

    property p_sec_wins;
        @(posedge clock_i) disable iff (!rst_n)
        ($past(sec_raw) != 4'h0) && !$past(lvl1_any) && $past(sec_ok)
            |-> (primary_sector_selects_o == 8'h00) && (secondary_sector_selects_o != 4'h0);
    endproperty
    a_sec_wins: assert property (p_sec_wins) else $error("primary beat secondary");

    property p_lvl1_wins;
        @(posedge clock_i) disable iff (!rst_n)
        (sram_select_o || register_block_select_o || (peripheral_selects_o != 2'h0))
            |-> (primary_sector_selects_o == 8'h00) && (secondary_sector_selects_o == 4'h0);
    endproperty
    a_lvl1_wins: assert property (p_lvl1_wins) else $error("flash beat level one");

    property p_fetch_gate;
        @(posedge clock_i) disable iff (!rst_n)
        program_fetch_strobe_i && !space_map[msd_pkg::VM_FETCH_PRI]
            |=> primary_sector_selects_o == 8'h00;
    endproperty
    a_fetch_gate: assert property (p_fetch_gate) else $error("blocked fetch reached");

    property p_read_gate;
        @(posedge clock_i) disable iff (!rst_n)
        read_strobe_i && !space_map[msd_pkg::VM_READ_SEC] |=> secondary_sector_selects_o == 4'h0;
    endproperty
    a_read_gate: assert property (p_read_gate) else $error("blocked read reached");

    property p_pio_off;
        @(posedge clock_i) disable iff (!rst_n)
        !space_map[msd_pkg::VM_PERIPHERAL_IO_ENABLE] |=> peripheral_selects_o == 2'h0;
    endproperty
    a_pio_off: assert property (p_pio_off) else $error("peripheral select while off");

    property p_page_write;
        @(posedge clock_i) disable iff (!rst_n)
        write_strobe_i && page_hit |=> page_bits_o == $past(data_i);
    endproperty
    a_page_write: assert property (p_page_write) else $error("page write lost");

    property p_standby;
        @(posedge clock_i) disable iff (!rst_n)
        (fast_mode_i || (vec != vec_q)) |=> !standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("standby while busy");

    property p_bus_drive;
        @(posedge clock_i) disable iff (!rst_n)
        data_oe_o |-> $past(read_strobe_i) && register_block_select_o;
    endproperty
    a_bus_drive: assert property (p_bus_drive) else $error("bus driven when idle");
endmodule : msd_decoder

// [testbench/msd_core_model.sv]
// Processor core model that runs bus cycles on the decoder's address and strobe inputs.
`timescale 1ns/1ps
module msd_core_model (
    input wire logic clock_i,
    output logic [15:0] addr_o,
    output logic fetch_o,
    output logic read_o,
    output logic write_o,
    output logic ale_o,
    output logic [7:0] data_o
);
    // The bus starts idle, at an address outside every window.
    initial
    begin
        addr_o = 16'h0000;
        fetch_o = 1'b0;
        read_o = 1'b0;
        write_o = 1'b0;
        ale_o = 1'b1;
        data_o = 8'h00;
    end

    // One bus cycle, entered at a falling edge; the rising edge takes it.
    // It ends on the next falling edge, where the registered answer has settled.
    // Data is only meaningful in a write; otherwise it shows the inverse, so stale
    // values never look valid.
    task automatic cycle(input logic [15:0] a, input logic [2:0] kind, input logic [7:0] d);
        addr_o = a;
        fetch_o = kind[2];
        read_o = kind[1];
        write_o = kind[0];
        ale_o = (kind == 3'h0);
        data_o = kind[0] ? d : ~data_o;
        @(posedge clock_i);
        @(negedge clock_i);
    endtask : cycle
endmodule : msd_core_model

// [testbench/tb.sv]
// Self-checking bench for the memory select decoder.
`timescale 1ns/1ps
module tb;
    localparam logic [2:0] K_IDLE = 3'h0;
    localparam logic [2:0] K_FETCH = 3'h4;
    localparam logic [2:0] K_READ = 3'h2;
    localparam logic [2:0] K_WRITE = 3'h1;
    // Select vector layout: primary[15:8], secondary[7:4], SRAM, register, peripheral[1:0].
    localparam logic [15:0] PRI0 = 16'h0100;
    localparam logic [15:0] SEC0 = 16'h0010;
    localparam logic [15:0] SRAM = 16'h0008;
    localparam logic [15:0] REGS = 16'h0004;
    localparam logic [15:0] PER0 = 16'h0001;
    logic clock;
    logic rst_b;
    logic fast_mode;
    logic bat_en;
    logic below;
    logic [21:0] port_in;
    logic [15:0] addr;
    logic fetch;
    logic read;
    logic write;
    logic ale;
    logic [7:0] wdata;
    logic [7:0] pri;
    logic [3:0] sec;
    logic sram;
    logic regsel;
    logic [1:0] peri;
    logic [7:0] page;
    logic [7:0] rdata;
    logic oe;
    logic bat;
    logic stby;
    int err_count;
    int compares;

    // Free-running 20 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    msd_core_model core (.clock_i(clock), .addr_o(addr), .fetch_o(fetch), .read_o(read),
        .write_o(write), .ale_o(ale), .data_o(wdata));

    // The default map overlaps the SRAM, secondary and primary windows at 8000h; priority keeps one select.
    msd_decoder DUT (.clock_i(clock), .rst_b_i(rst_b), .addr_i(addr),
        .program_fetch_strobe_i(fetch), .read_strobe_i(read), .write_strobe_i(write),
        .addr_latch_i(ale), .power_down_input_i(1'b0), .port_in_i(port_in),
        .group_a_feedback_i(8'h00), .group_b_feedback_i(8'h00), .flash_ready_i(1'b1),
        .data_i(wdata), .fast_mode_i(fast_mode), .battery_status_enable_i(bat_en),
        .supply_below_battery_i(below), .primary_sector_selects_o(pri),
        .secondary_sector_selects_o(sec), .sram_select_o(sram),
        .register_block_select_o(regsel), .peripheral_selects_o(peri), .page_bits_o(page),
        .data_o(rdata), .data_oe_o(oe), .battery_on_flag_o(bat), .standby_o(stby));

    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // One bus cycle followed by a compare of the whole select vector, which also
    // catches a second select that should not be there.
    task automatic dec(input logic [15:0] a, input logic [2:0] kind, input logic [15:0] exp);
        core.cycle(a, kind, 8'h00);
        check("selects", {pri, sec, sram, regsel, peri}, exp);
    endtask : dec

    // Register read at a register block offset, answered one edge later.
    task automatic reg_read(input logic [7:0] off, input logic [7:0] exp);
        core.cycle({8'hff, off}, K_READ, 8'h00);
        check("read data", {8'h00, rdata}, {8'h00, exp});
        check("drive enable", {15'h0000, oe}, 16'h0001);
    endtask : reg_read

    // Watchdog: the tests need well under a thousand cycles.
    initial
    begin
        #(50 * 3000);
        err_count++;
        test_done();
    end

    // Main sequence.
    initial
    begin
        err_count = 0;
        compares = 0;
        rst_b = 1'b0;
        fast_mode = 1'b1;
        bat_en = 1'b0;
        below = 1'b0;
        port_in = 22'h000000;
        repeat (4) @(posedge clock);
        @(negedge clock);
        check("reset selects", {pri, sec, sram, regsel, peri}, 16'h0000);
        check("reset page", {8'h00, page}, 16'h0000);
        rst_b = 1'b1;
        repeat (3) core.cycle(16'h0000, K_IDLE, 8'h00);
        check("page after boot", {8'h00, page}, 16'h0000);
        // Boot value of the space map and the page register.
        reg_read(msd_pkg::OFF_SPACE_MAP, msd_pkg::SPACE_MAP_BOOT);
        reg_read(msd_pkg::OFF_PAGE, 8'h00);
        // Separate spaces under the boot value: SRAM wins, then secondary, then primary.
        dec(16'h8000, K_READ, SRAM);
        dec(16'h8800, K_READ, SEC0);
        dec(16'ha000, K_READ, 16'h0000);
        dec(16'ha000, K_FETCH, PRI0);
        dec(16'ha000, K_WRITE, PRI0);
        dec(16'hc000, K_READ, 16'h0000);
        dec(16'hf000, K_READ, 16'h0000);
        dec(16'hff10, K_READ, REGS);
        check("refused offset", {15'h0000, oe}, 16'h0000);
        // Opening every path; the very next cycle must see the new map.
        core.cycle({8'hff, msd_pkg::OFF_SPACE_MAP}, K_WRITE, 8'h9f);
        dec(16'ha000, K_READ, PRI0);
        dec(16'hf000, K_READ, PER0);
        dec(16'h8000, K_FETCH, SRAM);
        dec(16'h9000, K_FETCH, SEC0);
        reg_read(msd_pkg::OFF_SPACE_MAP, 8'h9f);
        // Primary and SRAM reads stay open: every fetch and every secondary read is blocked,
        // so the shared window falls through to the primary sector for reads.
        core.cycle({8'hff, msd_pkg::OFF_SPACE_MAP}, K_WRITE, 8'h10);
        dec(16'h8800, K_READ, PRI0);
        dec(16'ha000, K_FETCH, 16'h0000);
        dec(16'h8000, K_FETCH, 16'h0000);
        dec(16'h9000, K_FETCH, 16'h0000);
        // Page write then read back to back.
        core.cycle({8'hff, msd_pkg::OFF_PAGE}, K_WRITE, 8'h5a);
        check("page bits", {8'h00, page}, 16'h005a);
        reg_read(msd_pkg::OFF_PAGE, 8'h5a);
        core.cycle(16'h0000, K_IDLE, 8'h00);
        check("bus released", {15'h0000, oe}, 16'h0000);
        // Battery flag for every pairing of enable and supply state.
        for (int i = 0; i < 4; i++)
        begin
            bat_en = i[1];
            below = i[0];
            core.cycle(16'h0000, K_IDLE, 8'h00);
            check("battery flag", {15'h0000, bat}, {15'h0000, i[1] & i[0]});
        end
        // Fast mode never sleeps; slow mode sleeps on quiet inputs and wakes on a change.
        repeat (5) core.cycle(16'h0000, K_IDLE, 8'h00);
        check("standby fast", {15'h0000, stby}, 16'h0000);
        fast_mode = 1'b0;
        repeat (5) core.cycle(16'h0000, K_IDLE, 8'h00);
        check("standby slow", {15'h0000, stby}, 16'h0001);
        port_in = 22'h000001;
        core.cycle(16'h0000, K_IDLE, 8'h00);
        check("standby wake", {15'h0000, stby}, 16'h0000);
        // A second reset mid-run must reload the boot map and clear the page.
        rst_b = 1'b0;
        core.cycle(16'h0000, K_IDLE, 8'h00);
        check("reset page again", {8'h00, page}, 16'h0000);
        rst_b = 1'b1;
        repeat (3) core.cycle(16'h0000, K_IDLE, 8'h00);
        reg_read(msd_pkg::OFF_SPACE_MAP, msd_pkg::SPACE_MAP_BOOT);
        reg_read(msd_pkg::OFF_PAGE, 8'h00);
        test_done();
    end
endmodule : tb
